// ### inc/esd_pkg.sv
// Shared constants and types for the encoder speed decoder
package esd_pkg;

	// ==========================================
	// Register byte offsets
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_LINES = 5'h04;
	localparam logic [4:0] OFS_RATIO = 5'h08;
	localparam logic [4:0] OFS_MAXRPM = 5'h0C;
	localparam logic [4:0] OFS_ENC_RPM = 5'h10;
	localparam logic [4:0] OFS_SPEED_PCT = 5'h14;
	localparam logic [4:0] OFS_STATUS = 5'h18;

	// ==========================================
	// Control register field positions
	localparam int CTRL_QUAD_POS = 0;
	localparam int CTRL_INV_POS = 1;
	localparam int CTRL_FBK_LSB = 2;
	localparam int CTRL_ORIENT_POS = 5;
	localparam int CTRL_W = 6;

	// ==========================================
	// Reset values
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam logic [15:0] LINES_RESET = 16'h0400;
	localparam logic [15:0] RATIO_RESET = 16'h0100;
	localparam logic [15:0] MAXRPM_RESET = 16'h05DC;

	// ==========================================
	// Feedback types that use encoder as trim only
	localparam logic [2:0] FBK_ENC_ARM = 3'h3;
	localparam logic [2:0] FBK_ENC_TACHO = 3'h4;

	// ==========================================
	// Timing and scaling
	localparam int CLK_MHZ = 50;
	localparam int SAMPLE_TIME_US = 10000;
	localparam int SAMPLE_CYCLES = CLK_MHZ * SAMPLE_TIME_US;
	localparam int RPM_FACTOR = 60000000 / SAMPLE_TIME_US;
	localparam int QUAD_EDGES = 4;
	localparam int PCT_FULL = 10000;
	localparam int RATIO_FRAC = 8;
	localparam int DIV_STEPS = 32;

	// ==========================================
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Control settings written by software
	typedef struct packed {
		logic orient_en;
		logic [2:0] fbk_type;
		logic dir_invert;
		logic quad_en;
	} esd_ctrl_t;

	// Arithmetic sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DIV_RPM = 2'b01,
		ST_DIV_PCT = 2'b10,
		ST_DONE = 2'b11
	} esd_state_t;

endpackage

// ### rtl/esd_decoder.sv
// Encoder speed decoder with AXI4-Lite register access
`timescale 1ns/1ps

module esd_decoder #(
	parameter int SAMPLE_CYCLES = esd_pkg::SAMPLE_CYCLES
) (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic [4:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [4:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic pulse_or_a_input_in,
	input wire logic direction_or_b_input_in,
	input wire logic analog_reverse_in,
	output logic signed [15:0] encoder_rpm_out,
	output logic signed [15:0] motor_speed_pct_out,
	output logic dir_input_free_out,
	output logic dir_input_level_out
);

	// ==========================================
	// Helper functions

	// One restoring division step: {remainder, quotient}
	function automatic logic [48:0] div_step(
		input logic [16:0] rem,
		input logic [31:0] quo,
		input logic [15:0] den
	);
		logic [16:0] trial;
		trial = {rem[15:0], quo[31]};
		if (trial >= {1'b0, den})
			div_step = {17'(trial - {1'b0, den}), quo[30:0], 1'b1};
		else
			div_step = {trial, quo[30:0], 1'b0};
	endfunction

	// Saturate a magnitude to 15 bits and apply the sign
	function automatic logic [15:0] sat_sign(
		input logic [31:0] mag,
		input logic neg
	);
		logic [15:0] lim;
		lim = (mag > 32'h00007FFF) ? 16'h7FFF : mag[15:0];
		sat_sign = neg ? 16'(-lim) : lim;
	endfunction

	// ==========================================
	// Registers and internal signals
	esd_pkg::esd_ctrl_t ctrl; // Mode settings
	logic [15:0] lines; // Lines per revolution
	logic [15:0] ratio; // Gear ratio, 8 fraction bits
	logic [15:0] max_rpm; // Full-scale motor speed
	logic a_s1, a_s2, a_d; // Pulse or A synchroniser
	logic b_s1, b_s2, b_d; // Direction or B synchroniser
	logic a_rise, a_edge, b_edge;
	logic step, step_up; // Count event and its sign
	logic analog_sign; // Sign taken from analog feedback
	logic [31:0] tick_cnt; // Window timer
	logic tick;
	logic signed [16:0] win_cnt; // Running signed edge count
	logic [16:0] snap_mag; // Magnitude of last window
	logic snap_neg; // Direction of last window
	logic snap_quad; // Format used for last window
	esd_pkg::esd_state_t state;
	logic [16:0] div_rem;
	logic [31:0] div_quo;
	logic [15:0] div_den;
	logic [4:0] div_cnt;
	logic [15:0] rpm_mag; // Encoder speed magnitude
	logic [31:0] motor_rpm; // Motor speed magnitude
	logic [48:0] next_div;
	logic [15:0] rpm_next; // Encoder rpm leaving the divider, saturated
	logic [31:0] motor_raw; // Motor rpm, encoder rpm times ratio
	logic [31:0] motor_lim; // Motor rpm clamped so the percent product fits
	// Largest motor rpm whose percent product still fits 32 bits
	localparam logic [31:0] MOTOR_CLAMP = 32'(32'hFFFFFFFF / esd_pkg::PCT_FULL);
	logic aw_held, w_held;
	logic [4:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_go;
	logic [31:0] rd_val;
	logic rd_ok;

	// ==========================================
	// Input synchronisers, two flops then edge detect
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			a_s1 <= 1'b0;
			a_s2 <= 1'b0;
			a_d <= 1'b0;
			b_s1 <= 1'b0;
			b_s2 <= 1'b0;
			b_d <= 1'b0;
		end
		else
		begin
			a_s1 <= pulse_or_a_input_in;
			a_s2 <= a_s1;
			a_d <= a_s2;
			b_s1 <= direction_or_b_input_in;
			b_s2 <= b_s1;
			b_d <= b_s2;
		end
	end

	// Single-sample edge detect, no filter so short pulses count
	assign a_edge = a_s2 ^ a_d;
	assign b_edge = b_s2 ^ b_d;
	assign a_rise = a_s2 & ~a_d;

	// Analog sign replaces direction pin in combined modes
	assign analog_sign = !ctrl.quad_en && !ctrl.orient_en &&
		(ctrl.fbk_type == esd_pkg::FBK_ENC_ARM ||
		ctrl.fbk_type == esd_pkg::FBK_ENC_TACHO);

	// Step decode for both formats
	always_comb
	begin
		if (ctrl.quad_en)
		begin
			// All four edges; both at once is illegal and ignored
			step = a_edge ^ b_edge;
			step_up = a_s2 ^ b_d;
		end
		else
		begin
			step = a_rise;
			step_up = analog_sign ? ~analog_reverse_in : b_s2;
		end
	end

	// Direction pin handed to other logic when freed
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			dir_input_free_out <= 1'b0;
			dir_input_level_out <= 1'b0;
		end
		else
		begin
			dir_input_free_out <= analog_sign;
			dir_input_level_out <= b_s2;
		end
	end

	// ==========================================
	// Sampling window timer
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			tick_cnt <= 32'h00000000;
		else if (tick)
			tick_cnt <= 32'h00000000;
		else
			tick_cnt <= tick_cnt + 32'h00000001;
	end

	assign tick = (tick_cnt == 32'(SAMPLE_CYCLES - 1));

	// Signed edge counter, restarted every window
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			win_cnt <= 17'sh00000;
			snap_mag <= 17'h00000;
			snap_neg <= 1'b0;
			snap_quad <= 1'b0;
		end
		else
		begin
			if (tick)
			begin
				// Edge in the tick cycle opens the next window
				snap_neg <= win_cnt[16];
				snap_mag <= win_cnt[16] ? 17'(-win_cnt) : win_cnt;
				snap_quad <= ctrl.quad_en;
				win_cnt <= 17'sh00000;
			end
			if (step)
			begin
				// Invert setting applies to both formats
				if (step_up ^ ctrl.dir_invert)
					win_cnt <= (tick ? 17'sh00000 : win_cnt) + 17'sh00001;
				else
					win_cnt <= (tick ? 17'sh00000 : win_cnt) - 17'sh00001;
			end
		end
	end

	// ==========================================
	// Arithmetic sequencer: rpm then percent, one divider
	assign next_div = div_step(div_rem, div_quo, div_den);

	// Saturate the quotient; zero lines gives zero speed, not all ones
	assign rpm_next = (div_den == 16'h0000) ? 16'h0000 :
		((next_div[31:16] != 16'h0000) ? 16'hFFFF : next_div[15:0]);
	assign motor_raw = (32'(rpm_next) * 32'(ratio)) >> esd_pkg::RATIO_FRAC;
	// Past the clamp the percent saturates anyway, so nothing is lost
	assign motor_lim = (motor_raw > MOTOR_CLAMP) ? MOTOR_CLAMP : motor_raw;

	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			state <= esd_pkg::ST_IDLE;
			div_rem <= 17'h00000;
			div_quo <= 32'h00000000;
			div_den <= 16'h0000;
			div_cnt <= 5'h00;
			rpm_mag <= 16'h0000;
			motor_rpm <= 32'h00000000;
		end
		else
		begin
			case (state)
				esd_pkg::ST_IDLE:
				begin
					// Edges to rpm: count * 60 / (window * lines), with lines taken four times over in quadrature
					if (tick)
					begin
						state <= esd_pkg::ST_DIV_RPM;
						div_rem <= 17'h00000;
						div_den <= lines;
						div_cnt <= 5'h00;
						if (ctrl.quad_en)
							div_quo <= 32'(win_cnt[16] ? 17'(-win_cnt) : win_cnt)
								* 32'(esd_pkg::RPM_FACTOR / esd_pkg::QUAD_EDGES);
						else
							div_quo <= 32'(win_cnt[16] ? 17'(-win_cnt) : win_cnt)
								* 32'(esd_pkg::RPM_FACTOR);
					end
				end
				esd_pkg::ST_DIV_RPM:
				begin
					div_rem <= next_div[48:32];
					div_quo <= next_div[31:0];
					div_cnt <= div_cnt + 5'h01;
					if (div_cnt == 5'(esd_pkg::DIV_STEPS - 1))
					begin
						// Encoder rpm done, start the percent division
						rpm_mag <= rpm_next;
						state <= esd_pkg::ST_DIV_PCT;
						div_rem <= 17'h00000;
						div_cnt <= 5'h00;
						div_den <= max_rpm;
						// Percent dividend, clamped input cannot wrap
						div_quo <= 32'(motor_lim * esd_pkg::PCT_FULL);
					end
				end
				esd_pkg::ST_DIV_PCT:
				begin
					div_rem <= next_div[48:32];
					div_quo <= next_div[31:0];
					div_cnt <= div_cnt + 5'h01;
					if (div_cnt == 5'(esd_pkg::DIV_STEPS - 1))
					begin
						motor_rpm <= (div_den == 16'h0000) ? 32'h00000000 :
							next_div[31:0];
						state <= esd_pkg::ST_DONE;
					end
				end
				esd_pkg::ST_DONE:
					state <= esd_pkg::ST_IDLE;
				default:
					state <= esd_pkg::ST_IDLE;
			endcase
		end
	end

	// Outputs update together once per window
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			encoder_rpm_out <= 16'sh0000;
			motor_speed_pct_out <= 16'sh0000;
		end
		else if (state == esd_pkg::ST_DONE)
		begin
			// Encoder only, whatever feedback type is chosen
			encoder_rpm_out <= sat_sign(32'(rpm_mag), snap_neg);
			motor_speed_pct_out <= sat_sign(motor_rpm, snap_neg);
		end
	end

	// ==========================================
	// AXI4-Lite write channel
	assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
	assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;
	assign wr_go = aw_held && w_held && !s_axi_bvalid_out;

	// Address and data may arrive in either order
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 5'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid_in && s_axi_awready_out)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_in;
			end
			else if (wr_go)
				aw_held <= 1'b0;
			if (s_axi_wvalid_in && s_axi_wready_out)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata_in;
				w_strb <= s_axi_wstrb_in;
			end
			else if (wr_go)
				w_held <= 1'b0;
		end
	end

	// Write response
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= esd_pkg::RESP_OKAY;
		end
		else if (wr_go)
		begin
			s_axi_bvalid_out <= 1'b1;
			// Read-only and unmapped words answer with an error
			if (aw_addr == esd_pkg::OFS_CTRL || aw_addr == esd_pkg::OFS_LINES ||
				aw_addr == esd_pkg::OFS_RATIO || aw_addr == esd_pkg::OFS_MAXRPM)
				s_axi_bresp_out <= esd_pkg::RESP_OKAY;
			else
				s_axi_bresp_out <= esd_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready_in)
			s_axi_bvalid_out <= 1'b0;
	end

	// Setting registers, byte lanes honoured
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			ctrl <= esd_pkg::CTRL_RESET;
			lines <= esd_pkg::LINES_RESET;
			ratio <= esd_pkg::RATIO_RESET;
			max_rpm <= esd_pkg::MAXRPM_RESET;
		end
		else if (wr_go)
		begin
			case (aw_addr)
				esd_pkg::OFS_CTRL:
					if (w_strb[0])
						ctrl <= w_data[esd_pkg::CTRL_W-1:0];
				esd_pkg::OFS_LINES:
				begin
					if (w_strb[0])
						lines[7:0] <= w_data[7:0];
					if (w_strb[1])
						lines[15:8] <= w_data[15:8];
				end
				esd_pkg::OFS_RATIO:
				begin
					if (w_strb[0])
						ratio[7:0] <= w_data[7:0];
					if (w_strb[1])
						ratio[15:8] <= w_data[15:8];
				end
				esd_pkg::OFS_MAXRPM:
				begin
					if (w_strb[0])
						max_rpm[7:0] <= w_data[7:0];
					if (w_strb[1])
						max_rpm[15:8] <= w_data[15:8];
				end
				default:
					ctrl <= ctrl;
			endcase
		end
	end

	// ==========================================
	// AXI4-Lite read channel
	assign s_axi_arready_out = !s_axi_rvalid_out;

	// Read decode
	always_comb
	begin
		rd_ok = 1'b1;
		case (s_axi_araddr_in)
			esd_pkg::OFS_CTRL: rd_val = {26'h0000000, ctrl};
			esd_pkg::OFS_LINES: rd_val = {16'h0000, lines};
			esd_pkg::OFS_RATIO: rd_val = {16'h0000, ratio};
			esd_pkg::OFS_MAXRPM: rd_val = {16'h0000, max_rpm};
			esd_pkg::OFS_ENC_RPM: rd_val = 32'(encoder_rpm_out);
			esd_pkg::OFS_SPEED_PCT: rd_val = 32'(motor_speed_pct_out);
			esd_pkg::OFS_STATUS:
				rd_val = {28'h0000000, analog_sign, snap_quad,
					(snap_mag != 17'h00000), snap_neg};
			default:
			begin
				rd_val = 32'h00000000;
				rd_ok = 1'b0;
			end
		endcase
	end

	// Read data held until taken
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h00000000;
			s_axi_rresp_out <= esd_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid_in && s_axi_arready_out)
		begin
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out <= rd_val;
			s_axi_rresp_out <= rd_ok ? esd_pkg::RESP_OKAY : esd_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready_in)
			s_axi_rvalid_out <= 1'b0;
	end

endmodule

// ### tb/esd_encoder_model.sv
// Behavioural shaft encoder driving the two encoder pins
`timescale 1ns/1ps
module esd_encoder_model #(
	parameter int QTR = 125 // Quarter period: 4*QTR cycles is 100 kHz at 50 MHz
) (
	input wire logic clk_in,
	input wire logic run_in,
	input wire logic quad_in,
	input wire logic rev_in,
	output logic a_out,
	output logic b_out
);
	int cnt = 0; // Quarter timer
	logic [1:0] ph = 2'h0; // Shaft phase
	// Advance one quarter; shaft stands still while not running
	always @(posedge clk_in)
	begin
		if (run_in)
		begin
			cnt <= (cnt == QTR - 1) ? 0 : cnt + 1;
			if (cnt == QTR - 1)
				ph <= rev_in ? ph - 2'h1 : ph + 2'h1;
		end
	end
	// Order 00,10,11,01: A leads B going forward
	assign a_out = ph[1] ^ ph[0];
	assign b_out = quad_in ? ph[1] : !rev_in;
endmodule

// ### tb/esd_decoder_monitor.sv
// Port-level checker for the encoder speed decoder
`timescale 1ns/1ps
module esd_decoder_monitor #(
	parameter int SAMPLE_CYCLES = esd_pkg::SAMPLE_CYCLES
) (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic [4:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic [1:0] s_axi_rresp_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic direction_or_b_input_in,
	input wire logic signed [15:0] encoder_rpm_out,
	input wire logic signed [15:0] motor_speed_pct_out,
	input wire logic dir_input_level_out
);
	// ==========
	// One clock domain
	default clocking mon_cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rstn_in);
	// Address and data taken together
	wire wr_both = s_axi_awvalid_in && s_axi_awready_out
		&& s_axi_wvalid_in && s_axi_wready_out;
	// ==========
	// Speed and direction outputs
	property p_zero;
		encoder_rpm_out == 16'sh0000 |-> ##[0:70] motor_speed_pct_out == 16'sh0000;
	endproperty
	a_zero: assert property (p_zero) else $error("pct not zero");
	property p_sign;
		encoder_rpm_out > 16'sh0000 |-> ##[0:70] motor_speed_pct_out >= 16'sh0000;
	endproperty
	a_sign: assert property (p_sign) else $error("pct sign");
	property p_hold;
		$changed(encoder_rpm_out) |=> $stable(encoder_rpm_out)[*8];
	endproperty
	a_hold: assert property (p_hold) else $error("rpm not held");
	property p_dsync;
		$stable(direction_or_b_input_in)[*4] |-> dir_input_level_out == direction_or_b_input_in;
	endproperty
	a_dsync: assert property (p_dsync) else $error("dir level");
	// ==========
	// Register bus
	property p_bhold;
		s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
	endproperty
	a_bhold: assert property (p_bhold) else $error("b dropped");
	property p_rhold;
		s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)
			&& $stable(s_axi_rresp_out);
	endproperty
	a_rhold: assert property (p_rhold) else $error("r dropped");
	property p_rans;
		s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
	endproperty
	a_rans: assert property (p_rans) else $error("no read answer");
	property p_roerr;
		wr_both && s_axi_awaddr_in[4] |=> ##1 s_axi_bvalid_out
			&& s_axi_bresp_out == esd_pkg::RESP_SLVERR;
	endproperty
	a_roerr: assert property (p_roerr) else $error("write not refused");
	c_write: cover property (wr_both);
	c_read: cover property (s_axi_arvalid_in && s_axi_arready_out);
	c_rev: cover property (encoder_rpm_out < 16'sh0000);
endmodule
bind esd_decoder esd_decoder_monitor #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) mon_u (
	.sys_clk_in, .rstn_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
	.s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
	.s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
	.s_axi_rready_in, .direction_or_b_input_in, .encoder_rpm_out, .motor_speed_pct_out,
	.dir_input_level_out
);

// ### tb/tb_esd_decoder.sv
// Self-checking bench for the encoder speed decoder
`timescale 1ns/1ps
module tb_esd_decoder;
	// ==========
	// Settings and signals
	localparam int WIN = 2500; // Short sampling window
	localparam logic [1:0] OK = esd_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = esd_pkg::RESP_SLVERR;
	typedef struct {
		logic [5:0] ctrl; // Control word
		logic [15:0] ratio; // Gear ratio
		logic [3:0] flg; // Run, pin reverse, analog reverse, pin freed
		logic signed [15:0] rlo, rhi, plo, phi; // Expected ranges
	} esd_row_t;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [4:0] awaddr = 5'h00, araddr = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic run = 1'b0, quad = 1'b0, rev = 1'b0, arev = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, pin_a, pin_b, dir_free;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic signed [15:0] rpm, pct;
	int errors = 0;
	int num_checks = 0;
	esd_row_t rows [14] = '{
		'{6'h00, 16'h0100, 4'h8, 16'h0FA0, 16'h1770, 16'h0FA0, 16'h1770},
		'{6'h00, 16'h0100, 4'hC, 16'hE890, 16'hF060, 16'hE890, 16'hF060},
		'{6'h02, 16'h0100, 4'hC, 16'h0FA0, 16'h1770, 16'h0FA0, 16'h1770},
		'{6'h01, 16'h0100, 4'h8, 16'h128E, 16'h1482, 16'h128E, 16'h1482},
		'{6'h01, 16'h0100, 4'hC, 16'hEB7E, 16'hED72, 16'hEB7E, 16'hED72},
		'{6'h03, 16'h0100, 4'hC, 16'h128E, 16'h1482, 16'h128E, 16'h1482},
		'{6'h00, 16'h0200, 4'h8, 16'h0FA0, 16'h1770, 16'h1F40, 16'h2EE0},
		'{6'h00, 16'hFF00, 4'h8, 16'h0FA0, 16'h1770, 16'h7FFF, 16'h7FFF},
		'{6'h00, 16'h0100, 4'h0, 16'h0000, 16'h0000, 16'h0000, 16'h0000},
		'{6'h04, 16'h0100, 4'h8, 16'h0FA0, 16'h1770, 16'h0FA0, 16'h1770},
		'{6'h0C, 16'h0100, 4'hB, 16'hE890, 16'hF060, 16'hE890, 16'hF060},
		'{6'h2C, 16'h0100, 4'hA, 16'h0FA0, 16'h1770, 16'h0FA0, 16'h1770},
		'{6'h10, 16'h0100, 4'hD, 16'h0FA0, 16'h1770, 16'h0FA0, 16'h1770},
		'{6'h11, 16'h0100, 4'hA, 16'h128E, 16'h1482, 16'h128E, 16'h1482}
	};
	// ==========
	// Design and far side
	esd_decoder #(.SAMPLE_CYCLES(WIN)) dut_u (
		.sys_clk_in(clk), .rstn_in(rstn), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
		.s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
		.s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.pulse_or_a_input_in(pin_a), .direction_or_b_input_in(pin_b), .analog_reverse_in(arev),
		.encoder_rpm_out(rpm), .motor_speed_pct_out(pct), .dir_input_free_out(dir_free),
		.dir_input_level_out()
	);
	esd_encoder_model enc_u (.clk_in(clk), .run_in(run), .quad_in(quad), .rev_in(rev),
		.a_out(pin_a), .b_out(pin_b));
	// ==========
	// Compare tasks
	task automatic check_val(input logic [33:0] got, input logic [33:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask
	task automatic check_range(input logic signed [15:0] g, lo, hi);
		num_checks++;
		if ((g >= lo && g <= hi) !== 1'b1)
		begin
			errors++;
			$display("wrong value at %0t: speed %0d not in %0d..%0d", $time, g, lo, hi);
		end
	endtask
	// ==========
	// Bus master: sample ready at negedge, act after the next posedge
	task automatic axi_write(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		logic done, ta, tw;
		done = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done)
		begin
			@(negedge clk);
			done = (bvalid === 1'b1);
			ta = (awready === 1'b1);
			tw = (wready === 1'b1);
			if (done) check_val({bresp, 32'h0}, {er, 32'h0});
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask
	task automatic axi_read(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic done, tk;
		done = 1'b0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done)
		begin
			@(negedge clk);
			done = (rvalid === 1'b1);
			tk = (arready === 1'b1);
			if (done) check_val({rresp, rdata}, {er, ed});
			@(posedge clk);
			if (tk) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ==========
	// Clock and watchdog
	initial
	begin
		forever #10 clk = ~clk;
	end
	initial
	begin
		repeat (90000) @(posedge clk);
		errors++;
		end_of_test();
	end
	// ==========
	// Main sequence
	initial
	begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		axi_read(esd_pkg::OFS_CTRL, 32'h00000000, OK);
		axi_read(esd_pkg::OFS_RATIO, 32'h00000100, OK);
		axi_read(esd_pkg::OFS_MAXRPM, 32'h000005DC, OK);
		axi_write(esd_pkg::OFS_ENC_RPM, 32'h00001234, ERR);
		axi_read(5'h1C, 32'h00000000, ERR);
		axi_write(esd_pkg::OFS_LINES, 32'h00000006, OK);
		axi_write(esd_pkg::OFS_MAXRPM, 32'h00002710, OK);
		axi_read(esd_pkg::OFS_ENC_RPM, 32'h00000000, OK);
		// Table of settings against expected speeds
		foreach (rows[i])
		begin
			@(posedge clk);
			run <= rows[i].flg[3];
			rev <= rows[i].flg[2];
			arev <= rows[i].flg[1];
			quad <= rows[i].ctrl[esd_pkg::CTRL_QUAD_POS];
			axi_write(esd_pkg::OFS_CTRL, {26'h0, rows[i].ctrl}, OK);
			axi_write(esd_pkg::OFS_RATIO, {16'h0, rows[i].ratio}, OK);
			repeat (2 * WIN + 200) @(posedge clk);
			@(negedge clk);
			check_range(rpm, rows[i].rlo, rows[i].rhi);
			check_range(pct, rows[i].plo, rows[i].phi);
			check_val({33'h0, dir_free}, {33'h0, rows[i].flg[0]});
		end
		// Last window: quadrature, forward, pulses seen
		axi_read(esd_pkg::OFS_STATUS, 32'h00000006, OK);
		// Free the direction pin so reset has something to clear
		axi_write(esd_pkg::OFS_CTRL, 32'h0000000C, OK);
		// Reset in mid-run clears outputs and settings
		@(posedge clk);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		check_range(rpm, 16'h0000, 16'h0000);
		check_range(pct, 16'h0000, 16'h0000);
		check_val({33'h0, dir_free}, 34'h0);
		rstn <= 1'b1;
		axi_read(esd_pkg::OFS_LINES, 32'h00000400, OK);
		axi_read(esd_pkg::OFS_CTRL, 32'h00000000, OK);
		axi_read(esd_pkg::OFS_RATIO, 32'h00000100, OK);
		axi_read(esd_pkg::OFS_SPEED_PCT, 32'h00000000, OK);
		axi_read(esd_pkg::OFS_STATUS, 32'h00000000, OK);
		end_of_test();
	end
endmodule
